// ===== tb_virtual_cpu_eoi_pending_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_virtual_cpu_eoi_pending_regs;
    logic sys_clk = 1'h0, rst_b = 1'h0, g0_pending_valid = 1'h1, acc_valid, acc_write, acc_done;
    logic fiq_route_to_virtual, irq_route_to_virtual, coproc_group12_trap, trap_all_group0;
    logic trap_all_group1, sysreg_enable_64, sysreg_enable_32, split_priority_drop_select;
    logic identifier_width_field, g1_pending_valid, prio_drop, prio_drop_grp1, deactivate;
    logic [9:0] cf = 10'h3c6;
    logic [3:0] acc_crn, acc_crm;
    logic [2:0] acc_opc2;
    logic [31:0] acc_wdata, acc_rdata;
    logic [23:0] g0_pending_id = 24'h5a0123, g1_pending_id = 24'h34abcd, op_identifier;
    vce_pkg::vce_dest_t acc_dest;
    int checked = 0, fail_count = 0;
    // one control word so each access names its whole setup
    assign {identifier_width_field, g1_pending_valid, fiq_route_to_virtual, irq_route_to_virtual,
        coproc_group12_trap, trap_all_group0, trap_all_group1, sysreg_enable_64,
        sysreg_enable_32, split_priority_drop_select} = cf;
    always #2.5 sys_clk = ~sys_clk;
    vce_core_mdl core_u (.sys_clk, .acc_valid, .acc_write, .acc_crn, .acc_crm, .acc_opc2,
        .acc_wdata);
    vce_eoi_pending dut_u (.sys_clk, .rst_b, .acc_valid, .acc_write, .acc_crn, .acc_crm,
        .acc_opc2, .acc_wdata, .acc_done, .acc_rdata, .acc_dest, .fiq_route_to_virtual,
        .irq_route_to_virtual, .coproc_group12_trap, .trap_all_group0, .trap_all_group1,
        .sysreg_enable_64, .sysreg_enable_32, .split_priority_drop_select,
        .identifier_width_field, .g0_pending_valid, .g0_pending_id, .g1_pending_valid,
        .g1_pending_id, .prio_drop, .prio_drop_grp1, .deactivate, .op_identifier);
    task automatic print_verdict;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // access then compare done, dest, read data, actions and held id in its answer cycle
    task automatic t(input logic [9:0] c, input logic w, input logic [3:0] m,
        input logic [2:0] o, input logic [2:0] ed, input logic [31:0] er,
        input logic [2:0] ea, input logic [23:0] eo);
        logic [62:0] ex;
        cf = c;
        core_u.put(w, m, o, (m == 4'hb) ? 32'h00000077 : 32'hff120042);
        ex = {ed != 3'h0, ed, er, ea, eo};
        checked++;
        if ({acc_done, acc_dest, acc_rdata, prio_drop, prio_drop_grp1, deactivate,
            op_identifier} !== ex) begin
            fail_count++;
            $display("Error access exp %h got %h", ex, {acc_done, acc_dest, acc_rdata,
                prio_drop, prio_drop_grp1, deactivate, op_identifier});
        end
        $display("test %0d done", checked);
        @(negedge sys_clk);
    endtask
    initial begin
        #2000 fail_count++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'h1;
        t(10'h3c6, 1'h1, 4'hc, 3'h1, 3'h1, 32'h0, 3'h7, 24'h120042);
        t(10'h1c7, 1'h1, 4'hc, 3'h1, 3'h1, 32'h0, 3'h6, 24'h000042);
        t(10'h1c7, 1'h1, 4'hb, 3'h1, 3'h1, 32'h0, 3'h1, 24'h000077);
        t(10'h1c7, 1'h1, 4'h8, 3'h1, 3'h1, 32'h0, 3'h4, 24'h000042);
        t(10'h3c7, 1'h0, 4'h8, 3'h2, 3'h1, 32'h005a0123, 3'h0, 24'h000042);
        t(10'h1c7, 1'h0, 4'hc, 3'h2, 3'h1, 32'h0000abcd, 3'h0, 24'h000042);
        t(10'h0c7, 1'h0, 4'hc, 3'h2, 3'h1, 32'h000003ff, 3'h0, 24'h000042);
        t(10'h386, 1'h1, 4'hc, 3'h1, 3'h2, 32'h0, 3'h0, 24'h000042);
        t(10'h346, 1'h0, 4'h8, 3'h2, 3'h2, 32'h0, 3'h0, 24'h000042);
        t(10'h386, 1'h0, 4'hc, 3'h2, 3'h2, 32'h0, 3'h0, 24'h000042);
        t(10'h3e6, 1'h1, 4'hc, 3'h1, 3'h3, 32'h0, 3'h0, 24'h000042);
        t(10'h3ce, 1'h1, 4'hc, 3'h1, 3'h3, 32'h0, 3'h0, 24'h000042);
        t(10'h3d6, 1'h0, 4'h8, 3'h2, 3'h3, 32'h0, 3'h0, 24'h000042);
        t(10'h3d6, 1'h0, 4'hc, 3'h2, 3'h1, 32'h0034abcd, 3'h0, 24'h000042);
        t(10'h3c2, 1'h1, 4'hc, 3'h1, 3'h4, 32'h0, 3'h0, 24'h000042);
        t(10'h3e0, 1'h1, 4'hc, 3'h1, 3'h5, 32'h0, 3'h0, 24'h000042);
        t(10'h3c6, 1'h1, 4'h9, 3'h1, 3'h0, 32'h0, 3'h0, 24'h000042);
        g0_pending_valid = 1'h0;
        t(10'h3c7, 1'h0, 4'h8, 3'h2, 3'h1, 32'h000003ff, 3'h0, 24'h000042);
        print_verdict();
    end
endmodule // tb_virtual_cpu_eoi_pending_regs
`default_nettype wire

// ===== vce_core_mdl.sv
`timescale 1ns/100ps
`default_nettype none
module vce_core_mdl (
    // clock
    input  wire logic       sys_clk,
    // access request
    output var logic        acc_valid,
    output var logic        acc_write,
    output var logic [3:0]  acc_crn,
    output var logic [3:0]  acc_crm,
    output var logic [2:0]  acc_opc2,
    output var logic [31:0] acc_wdata
);
    initial {acc_valid, acc_write, acc_crn, acc_crm, acc_opc2, acc_wdata} = 45'h0;
    // one access per call from a falling edge; write data is the d that the caller passes in
    task automatic put(input logic w, input logic [3:0] m, input logic [2:0] o,
        input logic [31:0] d);
        {acc_valid, acc_write, acc_crn, acc_crm, acc_opc2, acc_wdata} = {1'h1, w, 4'hc, m, o, d};
        @(negedge sys_clk);
        acc_valid = 1'h0;
        acc_wdata = ~d; // released data inverts so a stale value cannot pass
    endtask
endmodule // vce_core_mdl
`default_nettype wire

// ===== vce_defs.svh
`ifndef VCE_DEFS_SVH
`define VCE_DEFS_SVH
// instruction encoding fields (crn, crm, opc2)
`define VCE_CRN_GIC      4'hc
`define VCE_CRM_G0       4'h8
`define VCE_CRM_G1       4'hc
`define VCE_CRM_DEACT    4'hb
`define VCE_OPC2_EOI     3'h1
`define VCE_OPC2_PEND    3'h2
// identifier field layout
`define VCE_ID_W         24
`define VCE_ID16_MASK    24'h00ffff
`define VCE_ID_SPURIOUS  24'h0003ff
`define VCE_RSVD_ZERO    8'h00
// group count and response reset values
`define VCE_NUM_GRP      2
`define VCE_RDATA_RST    32'h0000_0000
`define VCE_ID_RST       24'h000000
`endif

// ===== vce_eoi_pending.sv
`timescale 1ns/100ps
`default_nettype none
`include "vce_defs.svh"
// Behaviour
// - eoi mode 0: group1 eoi write drops priority and deactivates the interrupt
// - eoi mode 1: group1 eoi write only drops priority
// - split mode: deactivate register write deactivates the named interrupt
// - registers are 32 bits, identifier in 23:0, 31:24 reserved
// - identifier is 16 or 24 bits per width field; 23:16 reserved if 16
// - group0 pending read returns highest pending group0 identifier
// - group1 pending read returns highest pending group1 identifier
// - unobservable highest pending reads as 1023 only
// - group1 eoi goes virtual only with irq routing set, else physical
// - group0 pending read goes virtual only with fiq routing set
// - group1 pending read goes virtual only with irq routing set
// - coprocessor group12 trap sends these accesses to hypervisor
// - trap all group1 sends group1 eoi and pending accesses to el2
// - trap all group0 sends group0 eoi and pending accesses to el2
// - 64-bit sysreg enable clear traps these accesses to el1
// - 32-bit sysreg enable clear makes these accesses undefined
// - crn c, crm c, opc2 1 write is group1 eoi
// - crn c, crm 8, opc2 1 write is group0 eoi
// - crn c, crm 8, opc2 2 read is group0 pending
module vce_eoi_pending (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // system register access from the core (non-secure el1)
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [3:0]  acc_crn,
    input  wire logic [3:0]  acc_crm,
    input  wire logic [2:0]  acc_opc2,
    input  wire logic [31:0] acc_wdata,
    output logic             acc_done,
    output logic [31:0]      acc_rdata,
    output vce_pkg::vce_dest_t acc_dest,
    // hypervisor routing, traps and enables
    input  wire logic        fiq_route_to_virtual,
    input  wire logic        irq_route_to_virtual,
    input  wire logic        coproc_group12_trap,
    input  wire logic        trap_all_group0,
    input  wire logic        trap_all_group1,
    input  wire logic        sysreg_enable_64,
    input  wire logic        sysreg_enable_32,
    // virtual interface control fields
    input  wire logic        split_priority_drop_select,
    input  wire logic        identifier_width_field,
    // highest pending state from the list registers
    input  wire logic        g0_pending_valid,
    input  wire logic [23:0] g0_pending_id,
    input  wire logic        g1_pending_valid,
    input  wire logic [23:0] g1_pending_id,
    // virtual interrupt state updates
    output logic             prio_drop,
    output logic             prio_drop_grp1,
    output logic             deactivate,
    output logic [23:0]      op_identifier
);

    // decoded request, used for both destination choice and action;
    // only the five encodings below are claimed, anything else in the
    // same crn space belongs to other registers and is left unanswered,
    // so acc_done stays low and the core's own decode must handle it
    function automatic vce_pkg::vce_reg_t decode_reg(
        input logic       wr,
        input logic [3:0] crn,
        input logic [3:0] crm,
        input logic [2:0] opc2
    );
        decode_reg = vce_pkg::VCE_REG_NONE;
        if (crn == `VCE_CRN_GIC) begin
            if (wr && crm == `VCE_CRM_G1 && opc2 == `VCE_OPC2_EOI)
                decode_reg = vce_pkg::VCE_REG_EOI1;
            else if (wr && crm == `VCE_CRM_G0 && opc2 == `VCE_OPC2_EOI)
                decode_reg = vce_pkg::VCE_REG_EOI0;
            else if (!wr && crm == `VCE_CRM_G0 && opc2 == `VCE_OPC2_PEND)
                decode_reg = vce_pkg::VCE_REG_PEND0;
            else if (!wr && crm == `VCE_CRM_G1 && opc2 == `VCE_OPC2_PEND)
                decode_reg = vce_pkg::VCE_REG_PEND1;
            else if (wr && crm == `VCE_CRM_DEACT && opc2 == `VCE_OPC2_EOI)
                decode_reg = vce_pkg::VCE_REG_DEACT;
        end
    endfunction

    // clip an identifier to the implemented width; with 16-bit ids the
    // upper byte of the field is reserved, so it reads zero and written
    // ones there can never name a different interrupt
    function automatic logic [23:0] clip_id(input logic wide, input logic [23:0] id);
        clip_id = wide ? id : (id & `VCE_ID16_MASK);
    endfunction

    vce_pkg::vce_reg_t  reg_sel;
    vce_pkg::vce_dest_t dest_d,  dest_q;
    logic               done_d,  done_q;
    logic [31:0]        rdata_d, rdata_q;
    logic               drop_d,  drop_q;
    logic               drop1_d, drop1_q;
    logic               deact_d, deact_q;
    logic [23:0]        id_d,    id_q;
    logic               is_g1;
    logic               route_virt;
    logic [23:0]        wr_id;

    // trap outcome, kept apart from routing so the priority order
    // can be read in one place and checked against the enables
    logic               trap_hit;
    vce_pkg::vce_dest_t trap_dest;
    // group 0 class: the deactivate register is in neither class
    logic               is_g0_class;
    // per-group pending words, index 0 for group 0 and 1 for group 1
    logic [1:0]         pend_valid;
    logic [1:0][23:0]   pend_id;
    logic [1:0][31:0]   pend_word;

    assign reg_sel = decode_reg(acc_write, acc_crn, acc_crm, acc_opc2);
    assign is_g1   = (reg_sel == vce_pkg::VCE_REG_EOI1) || (reg_sel == vce_pkg::VCE_REG_PEND1);
    // reserved write bits never reach the interrupt state
    assign wr_id   = clip_id(identifier_width_field, acc_wdata[23:0]);

    // access classes; the deactivate register belongs to neither group
    // because its group is only known from the identifier, which this
    // block does not look up (list register state lives outside)
    assign is_g0_class = (reg_sel == vce_pkg::VCE_REG_EOI0) ||
                         (reg_sel == vce_pkg::VCE_REG_PEND0);

    // both pending words are built every cycle; a read then only selects
    // one, which keeps the read path as short as the write path
    assign pend_valid = {g1_pending_valid, g0_pending_valid};
    assign pend_id    = {g1_pending_id, g0_pending_id};
    genvar grp;
    generate
        for (grp = 0; grp < `VCE_NUM_GRP; grp++) begin : g_pend
            // no observable pending interrupt reads as the spurious id, never stale
            assign pend_word[grp] = {`VCE_RSVD_ZERO, pend_valid[grp] ?
                clip_id(identifier_width_field, pend_id[grp]) : `VCE_ID_SPURIOUS};
        end
    endgenerate

    // routing: each group follows its own routing bit; the deactivate
    // register follows either bit, since the group of the named id is
    // not known here; a deactivate for a group that is not virtualised
    // is therefore a guest error that this block cannot catch
    always_comb begin
        case (reg_sel)
            vce_pkg::VCE_REG_EOI1:  route_virt = irq_route_to_virtual;
            vce_pkg::VCE_REG_PEND1: route_virt = irq_route_to_virtual;
            vce_pkg::VCE_REG_PEND0: route_virt = fiq_route_to_virtual;
            vce_pkg::VCE_REG_EOI0:  route_virt = fiq_route_to_virtual;
            vce_pkg::VCE_REG_DEACT: route_virt = fiq_route_to_virtual | irq_route_to_virtual;
            default:                route_virt = 1'b0;
        endcase
    end

    // trap checks in fixed order: undefined, el1, then the hypervisor traps;
    // a trapped access is answered with its destination and changes no state,
    // so software at the higher level can emulate it without side effects
    always_comb begin
        trap_hit  = 1'b1;
        trap_dest = vce_pkg::VCE_DEST_NONE;
        if (!sysreg_enable_32)
            trap_dest = vce_pkg::VCE_DEST_UNDEF;
        else if (!sysreg_enable_64)
            trap_dest = vce_pkg::VCE_DEST_TRAP_EL1;
        else if (coproc_group12_trap)
            trap_dest = vce_pkg::VCE_DEST_TRAP_EL2;
        else if (is_g1 && trap_all_group1)
            trap_dest = vce_pkg::VCE_DEST_TRAP_EL2;
        else if (is_g0_class && trap_all_group0)
            trap_dest = vce_pkg::VCE_DEST_TRAP_EL2;
        else
            trap_hit = 1'b0;
    end

    // next response: traps first, then routing, then the virtual action
    always_comb begin
        dest_d  = vce_pkg::VCE_DEST_NONE;
        done_d  = 1'b0;
        rdata_d = 32'h0000_0000;
        drop_d  = 1'b0;
        drop1_d = 1'b0;
        deact_d = 1'b0;
        id_d    = id_q;
        if (acc_valid && reg_sel != vce_pkg::VCE_REG_NONE) begin
            done_d = 1'b1;
            if (trap_hit)
                dest_d = trap_dest;
            else if (!route_virt)
                dest_d = vce_pkg::VCE_DEST_PHYS;
            else begin
                dest_d = vce_pkg::VCE_DEST_VIRT;
                case (reg_sel)
                    vce_pkg::VCE_REG_EOI0, vce_pkg::VCE_REG_EOI1: begin
                        // id trusted to match the last acknowledge; no check here,
                        // so a guest that breaks the order drops the wrong priority
                        // and only the outer state tracking can notice it
                        drop_d  = 1'b1;
                        drop1_d = (reg_sel == vce_pkg::VCE_REG_EOI1);
                        deact_d = !split_priority_drop_select;
                        id_d    = wr_id;
                    end
                    vce_pkg::VCE_REG_DEACT: begin
                        deact_d = split_priority_drop_select;
                        id_d    = wr_id;
                    end
                    vce_pkg::VCE_REG_PEND0: begin
                        rdata_d = pend_word[0];
                    end
                    vce_pkg::VCE_REG_PEND1: begin
                        rdata_d = pend_word[1];
                    end
                    default: ;
                endcase
            end
        end
    end

    // response registers; every output is a flop so the core sees
    // a clean one-cycle answer, at the cost of one cycle of latency;
    // reset clears the pulses and the held identifier, so a look at
    // it right after reset never shows a stale id
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dest_q  <= vce_pkg::VCE_DEST_NONE;
            done_q  <= 1'b0;
            rdata_q <= `VCE_RDATA_RST;
            drop_q  <= 1'b0;
            drop1_q <= 1'b0;
            deact_q <= 1'b0;
            id_q    <= `VCE_ID_RST;
        end else begin
            dest_q  <= dest_d;
            done_q  <= done_d;
            rdata_q <= rdata_d;
            drop_q  <= drop_d;
            drop1_q <= drop1_d;
            deact_q <= deact_d;
            id_q    <= id_d;
        end
    end

    // outputs: pulses stand one cycle, op_identifier holds the id of
    // the last virtual end of interrupt or deactivate until the next one
    assign acc_done      = done_q;
    assign acc_dest      = dest_q;
    assign acc_rdata     = rdata_q;
    assign prio_drop     = drop_q;
    assign prio_drop_grp1 = drop1_q;
    assign deactivate    = deact_q;
    assign op_identifier = id_q;

endmodule // vce_eoi_pending
`default_nettype wire

// ===== vce_eoi_pending_chk.sv
`timescale 1ns/100ps
`default_nettype none
module vce_chk (
    // clock and reset
    input wire logic               sys_clk,
    input wire logic               rst_b,
    // access port
    input wire logic               acc_valid,
    input wire logic               acc_write,
    input wire logic [3:0]         acc_crn,
    input wire logic [3:0]         acc_crm,
    input wire logic [2:0]         acc_opc2,
    input wire logic               acc_done,
    input wire logic [31:0]        acc_rdata,
    input wire vce_pkg::vce_dest_t acc_dest,
    // controls and state
    input wire logic               irq_route_to_virtual,
    input wire logic               coproc_group12_trap,
    input wire logic               trap_all_group1,
    input wire logic               sysreg_enable_64,
    input wire logic               sysreg_enable_32,
    input wire logic               split_priority_drop_select,
    input wire logic               g1_pending_valid,
    input wire logic               prio_drop,
    input wire logic               prio_drop_grp1,
    input wire logic               deactivate
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic e1, p1, dec, ok;
    // decoded encodings; ok means both enables are set and the coprocessor group12 trap is clear
    assign e1 = acc_valid & acc_write & acc_crn == 4'hc & acc_crm == 4'hc & acc_opc2 == 3'h1;
    assign p1 = acc_valid & !acc_write & acc_crn == 4'hc & acc_crm == 4'hc & acc_opc2 == 3'h2;
    assign dec = acc_valid & acc_crn == 4'hc & ((acc_write & acc_opc2 == 3'h1
        & acc_crm inside {4'h8, 4'hb, 4'hc}) | (!acc_write & acc_opc2 == 3'h2
        & acc_crm inside {4'h8, 4'hc}));
    assign ok = sysreg_enable_32 & sysreg_enable_64 & !coproc_group12_trap;
    a_done_decoded: assert property (dec |=> acc_done) else $error("no done");
    a_undef_first: assert property (dec & !sysreg_enable_32 |=>
        acc_dest == vce_pkg::VCE_DEST_UNDEF) else $error("not undefined");
    a_el1_trap: assert property (dec & sysreg_enable_32 & !sysreg_enable_64 |=>
        acc_dest == vce_pkg::VCE_DEST_TRAP_EL1) else $error("no el1 trap");
    a_group12_trap: assert property (dec & sysreg_enable_32 & sysreg_enable_64
        & coproc_group12_trap |=> acc_dest == vce_pkg::VCE_DEST_TRAP_EL2) else $error("no trap");
    a_tall1_trap: assert property ((e1 | p1) & ok & trap_all_group1 |=>
        acc_dest == vce_pkg::VCE_DEST_TRAP_EL2) else $error("no group1 trap");
    a_eoi1_route: assert property (e1 & ok & !trap_all_group1 |=> acc_dest ==
        ($past(irq_route_to_virtual) ? vce_pkg::VCE_DEST_VIRT : vce_pkg::VCE_DEST_PHYS))
        else $error("eoi route wrong");
    a_eoi1_mode: assert property (e1 & ok & !trap_all_group1 & irq_route_to_virtual |=>
        prio_drop & prio_drop_grp1 & deactivate == !$past(split_priority_drop_select))
        else $error("eoi action wrong");
    a_spur_read: assert property (p1 & ok & !trap_all_group1 & irq_route_to_virtual
        & !g1_pending_valid |=> acc_rdata == 32'h000003ff) else $error("not 1023");
    a_rsvd_zero: assert property (acc_done |-> acc_rdata[31:24] == 8'h00)
        else $error("reserved bits set");
endmodule // vce_chk
bind vce_eoi_pending vce_chk chk_u (.sys_clk, .rst_b, .acc_valid, .acc_write, .acc_crn,
    .acc_crm, .acc_opc2, .acc_done, .acc_rdata, .acc_dest, .irq_route_to_virtual,
    .coproc_group12_trap, .trap_all_group1, .sysreg_enable_64, .sysreg_enable_32,
    .split_priority_drop_select, .g1_pending_valid, .prio_drop, .prio_drop_grp1, .deactivate);
`default_nettype wire

// ===== vce_pkg.sv
package vce_pkg;
    // where an access goes after routing and trap checks
    typedef enum logic [2:0] {
        VCE_DEST_NONE,
        VCE_DEST_VIRT,
        VCE_DEST_PHYS,
        VCE_DEST_TRAP_EL2,
        VCE_DEST_TRAP_EL1,
        VCE_DEST_UNDEF
    } vce_dest_t;
    // which register the encoding names
    typedef enum logic [2:0] {
        VCE_REG_NONE,
        VCE_REG_EOI0,
        VCE_REG_EOI1,
        VCE_REG_PEND0,
        VCE_REG_PEND1,
        VCE_REG_DEACT
    } vce_reg_t;
endpackage
